// File: design/fsr_status_two.sv
// Purpose: Second status register of a serial flash with an AXI4-Lite register port.
// Assumes: Commands and events arrive as one-cycle pulses from logic on sys_clk_i.
// Notes: Reset pins pass through a two-flop synchroniser before use.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "fsr_regs.svh"

//Contract
//- Suspend command while an operation runs sets suspend flag, bit 7.
//- Resume, reset pin, JEDEC reset or software reset clears suspend flag.
//- Suspend flag hardware only, resets to 0, writes ignored.
//- Invert bit 6 is read/write, resets to 0, 1 reverses protection.
//- With invert set, protected regions unlock and unprotected regions lock.
//- Security register 0 is always locked against programming.
//- Three lock flags are read only and reset to 0.
//- Programming the last byte of a security register sets its flag.
//- Bit 5 is register 3, bit 4 register 2, bit 3 register 1.
//- A set lock flag never clears and blocks further programming; here rst_n_i clears it.
module fsr_status_two (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic op_busy_i,
    input wire logic hw_reset_pin_n_i,
    input wire logic jedec_reset_i,
    input wire logic otp_prog_last_i,
    input wire logic [1:0] otp_prog_sel_i,
    input wire fsr_pkg::fsr_prot_t prot_cfg_i,
    input wire logic [15:0] region_base_prot_i,
    output fsr_pkg::fsr_status_t status_o,
    output logic [15:0] region_prot_o,
    output logic [3:0] otp_prog_block_o
);
    import fsr_pkg::*;

    logic suspend_flag;
    logic protect_invert;
    logic [2:0] otp_lock_flags;
    logic reset_enabled;
    logic [1:0] pin_sync;
    logic [1:0] jedec_sync;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic sw_cmd_pulse;
    logic [7:0] sw_cmd_code;
    logic hw_reset_evt;
    logic cmd_evt;
    logic [7:0] cmd_evt_code;
    logic do_write;
    logic soft_reset_hit;
    logic suspend_clear;
    logic suspend_set;

    // Software can inject commands through the command register as well as the serial port.
    assign cmd_evt = cmd_valid_i | sw_cmd_pulse;
    assign cmd_evt_code = sw_cmd_pulse ? sw_cmd_code : cmd_code_i;
    assign hw_reset_evt = ~pin_sync[1] | jedec_sync[1];
    assign do_write = aw_held & w_held & ~s_axi_bvalid;
    // A software reset is the enable code alone or the reset code right after it.
    assign soft_reset_hit = cmd_evt && (cmd_evt_code == `FSR_CMD_RESET_ENABLE ||
                                        (cmd_evt_code == `FSR_CMD_RESET && reset_enabled));
    assign suspend_clear = hw_reset_evt || (cmd_evt && cmd_evt_code == `FSR_CMD_RESUME) ||
                           soft_reset_hit;
    assign suspend_set = cmd_evt && cmd_evt_code == `FSR_CMD_SUSPEND && op_busy_i;

    function automatic logic [31:0] status_word(input logic s, input logic i,
                                                input logic [2:0] l);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`FSR_BIT_SUSPEND] = s;
        w[`FSR_BIT_INVERT] = i;
        w[`FSR_BIT_LOCK3:`FSR_BIT_LOCK1] = l;
        return w;
    endfunction

    function automatic logic addr_mapped(input logic [11:0] a);
        return (a == `FSR_OFF_STATUS2) || (a == `FSR_OFF_CMD) ||
               (a == `FSR_OFF_PROT) || (a == `FSR_OFF_LOCKS);
    endfunction

    // Inversion is a plain per-region flip; the region decode itself lives outside.
    function automatic logic [15:0] apply_invert(input logic inv, input logic [15:0] base);
        return inv ? ~base : base;
    endfunction

    // The pin idles high, so its flops reset high and no false clear follows reset.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_sync <= 2'h3;
        end else begin
            pin_sync <= {pin_sync[0], hw_reset_pin_n_i};
        end
    end

    // The bus reset arrives from another domain and is only read after the second flop.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            jedec_sync <= 2'h0;
        end else begin
            jedec_sync <= {jedec_sync[0], jedec_reset_i};
        end
    end

    // The reset code needs the enable code right before it; any other code disarms it.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_enabled <= 1'b0;
        end else if (cmd_evt) begin
            reset_enabled <= (cmd_evt_code == `FSR_CMD_RESET_ENABLE);
        end
    end

    // Clear wins over set, so a reset that lands with a suspend never leaves the flag up.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            suspend_flag <= 1'b0;
        end else if (suspend_clear) begin
            suspend_flag <= 1'b0;
        end else if (suspend_set) begin
            suspend_flag <= 1'b1;
        end
    end

    // Only byte lane 0 carries the bit; the other lanes are ignored.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            protect_invert <= 1'b0;
        end else if (do_write && aw_addr == `FSR_OFF_STATUS2 && w_strb[0]) begin
            protect_invert <= w_data[`FSR_BIT_INVERT];
        end
    end

    // Flags are sticky; a real part keeps them in nonvolatile cells, here only reset clears.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            otp_lock_flags <= 3'h0;
        end else if (otp_prog_last_i && otp_prog_sel_i != 2'h0) begin
            otp_lock_flags[otp_prog_sel_i - 2'h1] <= 1'b1;
        end
    end

    // Status leaves through a flop so the port never shows a half-updated flag set.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_o <= '0;
        end else begin
            status_o <= '{suspend: suspend_flag, invert: protect_invert, locks: otp_lock_flags};
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            region_prot_o <= 16'h0000;
        end else begin
            region_prot_o <= apply_invert(protect_invert, region_base_prot_i);
        end
    end

    // Register 0 stays blocked even in reset, since its content is fixed at manufacture.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            otp_prog_block_o <= 4'h1;
        end else begin
            otp_prog_block_o <= {otp_lock_flags, 1'b1};
        end
    end

    // Address channel: ready pulses for one cycle so a held valid is taken only once.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
        end
    end

    // Data channel mirrors the address channel; either may arrive first.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= ~w_held & ~s_axi_wready & ~s_axi_bvalid;
        end
    end

    // The response waits for both halves, so a lone address never commits a write.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FSR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_mapped(aw_addr) ? `FSR_RESP_OKAY : `FSR_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // A command written by software acts one cycle after the write is committed.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_cmd_pulse <= 1'b0;
            sw_cmd_code <= 8'h00;
        end else begin
            sw_cmd_pulse <= do_write && aw_addr == `FSR_OFF_CMD && w_strb[0];
            if (do_write && aw_addr == `FSR_OFF_CMD) begin
                sw_cmd_code <= w_data[7:0];
            end
        end
    end

    // Reads answer one cycle after the address is taken; arready stays low while data waits.
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FSR_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FSR_RESP_OKAY;
            unique case (s_axi_araddr)
                `FSR_OFF_STATUS2: begin
                    s_axi_rdata <= status_word(suspend_flag, protect_invert, otp_lock_flags);
                end
                `FSR_OFF_CMD: begin
                    s_axi_rdata <= {24'h000000, sw_cmd_code};
                end
                `FSR_OFF_PROT: begin
                    s_axi_rdata <= {27'h0000000, prot_cfg_i};
                end
                `FSR_OFF_LOCKS: begin
                    s_axi_rdata <= {28'h0000000, otp_lock_flags, 1'b1};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `FSR_RESP_SLVERR;
                end
            endcase
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: design/fsr_regs.svh
// Purpose: Offsets, field positions, reset values and codes for the second status register.
// Assumes: Registers are 32-bit aligned words on an AXI4-Lite slave.
// Notes: Definitions only.
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH
`define FSR_OFF_STATUS2 12'h000
`define FSR_OFF_CMD 12'h004
`define FSR_OFF_PROT 12'h008
`define FSR_OFF_LOCKS 12'h00c
`define FSR_BIT_SUSPEND 7
`define FSR_BIT_INVERT 6
`define FSR_BIT_LOCK3 5
`define FSR_BIT_LOCK2 4
`define FSR_BIT_LOCK1 3
`define FSR_STATUS2_RESET 8'h00
`define FSR_CMD_SUSPEND 8'h75
`define FSR_CMD_RESUME 8'h7a
`define FSR_CMD_RESET_ENABLE 8'h66
`define FSR_CMD_RESET 8'h99
`define FSR_RESP_OKAY 2'b00
`define FSR_RESP_SLVERR 2'b10
`endif

// File: design/fsr_pkg.sv
// Purpose: Types shared by the second status register block.
// Assumes: Nothing beyond SystemVerilog packed structs.
// Notes: Holds types only.
package fsr_pkg;
    typedef struct packed {
        logic suspend;
        logic invert;
        logic [2:0] locks;
    } fsr_status_t;
    typedef struct packed {
        logic granule_select;
        logic direction;
        logic [2:0] field;
    } fsr_prot_t;
endpackage

// File: sim/fsr_status_two_monitor.sv
// Purpose: Port assertions for the second status register.
// Assumes: Bound to the block; synchroniser lag is three cycles at most.
// Notes: Clears are given two edges because status_o is registered.
`timescale 1ns/10ps
`default_nettype none
module fsr_status_two_monitor (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic op_busy_i,
    input wire logic hw_reset_pin_n_i,
    input wire logic jedec_reset_i,
    input wire logic otp_prog_last_i,
    input wire logic [1:0] otp_prog_sel_i,
    input wire fsr_pkg::fsr_status_t status_o,
    input wire logic [3:0] otp_prog_block_o
);
    import fsr_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence cmd_s(logic [7:0] c);
        cmd_valid_i && cmd_code_i == c;
    endsequence
    suspend_flag_set_a: assert property (cmd_s(8'h75) ##0 (op_busy_i && hw_reset_pin_n_i && !jedec_reset_i)
        |-> ##[1:2] status_o.suspend) else $error("suspend flag not set");
    resume_clr_a: assert property (cmd_s(8'h7a) |-> ##[1:2] !status_o.suspend)
        else $error("resume left suspend flag set");
    soft_clr_a: assert property (cmd_s(8'h66) |-> ##[1:2] !status_o.suspend)
        else $error("software reset left suspend flag set");
    pin_clr_a: assert property (!hw_reset_pin_n_i [*4] |-> ##[0:1] !status_o.suspend)
        else $error("reset pin left suspend flag set");
    jedec_clr_a: assert property (jedec_reset_i [*4] |-> ##[0:1] !status_o.suspend)
        else $error("bus reset left suspend flag set");
    lock_set_a: assert property (otp_prog_last_i && otp_prog_sel_i != 2'h0
        |-> ##2 status_o.locks[$past(otp_prog_sel_i, 2) - 2'h1]) else $error("lock flag not set");
    lock_keep_a: assert property (1'b1 |=> ($past(status_o.locks) & ~status_o.locks) == 3'h0)
        else $error("lock flag cleared");
    block_map_a: assert property (otp_prog_block_o == {status_o.locks, 1'b1})
        else $error("program block map wrong");
endmodule
`default_nettype wire

// File: sim/fsr_host_model.sv
// Purpose: Host controller that sends flash command codes.
// Assumes: Each command is valid for one clock.
// Notes: Released code lines show the inverse of the last code.
`timescale 1ns/10ps
`default_nettype none
module fsr_host_model (
    input wire logic sys_clk_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o
);
    initial cmd_valid_o = 1'b0;
    initial cmd_code_o = 8'h00;
    task automatic issue(input logic [7:0] code);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_flash_status_reg_two.sv
// Purpose: Self-checking bench for the second status register.
// Assumes: AXI4-Lite master tasks and the host model drive the block.
// Notes: Pins are held six cycles so the synchroniser sees them.
`timescale 1ns/10ps
`default_nettype none
`include "fsr_regs.svh"
module tb_flash_status_reg_two;
    import fsr_pkg::*;
    logic sys_clk_i = 1'b0, rst_n_i = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, op_busy_i = 1'b0;
    logic hw_reset_pin_n_i = 1'b1, jedec_reset_i = 1'b0, otp_prog_last_i = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmd_valid_i;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf, otp_prog_block_o;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, otp_prog_sel_i = 2'h0;
    logic [7:0] cmd_code_i;
    logic [15:0] region_base_prot_i = 16'h8000, region_prot_o;
    fsr_prot_t prot_cfg_i = '0;
    fsr_status_t status_o;
    int n_errors = 0, checks_done = 0;
    fsr_status_two i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
        .op_busy_i(op_busy_i), .hw_reset_pin_n_i(hw_reset_pin_n_i),
        .jedec_reset_i(jedec_reset_i), .otp_prog_last_i(otp_prog_last_i),
        .otp_prog_sel_i(otp_prog_sel_i), .prot_cfg_i(prot_cfg_i),
        .region_base_prot_i(region_base_prot_i), .status_o(status_o),
        .region_prot_o(region_prot_o), .otp_prog_block_o(otp_prog_block_o));
    fsr_host_model i_host (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    // Both directions share one task; the unused channel stays idle.
    task automatic axi(input logic w, input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            rd = s_axi_rdata;
            rs = w ? s_axi_bresp : s_axi_rresp;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic t_regs;
        axi(1'b0, `FSR_OFF_STATUS2, 32'h0);
        chk("status reset", 32'h0, rd);
        axi(1'b0, `FSR_OFF_LOCKS, 32'h0);
        chk("lock map", 32'h1, rd);
        prot_cfg_i <= 5'h15;
        axi(1'b0, `FSR_OFF_PROT, 32'h0);
        chk("protect config", 32'h15, rd);
        axi(1'b1, `FSR_OFF_STATUS2, 32'hffffffff);
        axi(1'b0, `FSR_OFF_STATUS2, 32'h0);
        chk("status write", 32'h40, rd);
        repeat (3) @(posedge sys_clk_i);
        chk("region invert", 32'h7fff, {16'h0, region_prot_o});
        axi(1'b1, `FSR_OFF_STATUS2, 32'h0);
        repeat (3) @(posedge sys_clk_i);
        chk("region plain", 32'h8000, {16'h0, region_prot_o});
        axi(1'b1, 12'h010, 32'h1);
        chk("unmapped write", {30'h0, `FSR_RESP_SLVERR}, {30'h0, rs});
        $display("register test done");
    endtask
    task automatic t_suspend_flag;
        for (int m = 0; m < 5; m++) begin
            op_busy_i <= 1'b1;
            i_host.issue(`FSR_CMD_SUSPEND);
            repeat (3) @(posedge sys_clk_i);
            chk("suspend set", 32'h1, {31'h0, status_o.suspend});
            case (m)
                0: i_host.issue(`FSR_CMD_RESUME);
                1: i_host.issue(`FSR_CMD_RESET_ENABLE);
                2: hw_reset_pin_n_i <= 1'b0;
                3: jedec_reset_i <= 1'b1;
                default: axi(1'b1, `FSR_OFF_CMD, {24'h0, `FSR_CMD_RESUME});
            endcase
            repeat (6) @(posedge sys_clk_i);
            hw_reset_pin_n_i <= 1'b1;
            jedec_reset_i <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            chk("suspend clear", 32'h0, {31'h0, status_o.suspend});
        end
        axi(1'b0, `FSR_OFF_CMD, 32'h0);
        chk("command code", {24'h0, `FSR_CMD_RESUME}, rd);
        op_busy_i <= 1'b0;
        i_host.issue(`FSR_CMD_SUSPEND);
        repeat (3) @(posedge sys_clk_i);
        chk("suspend idle", 32'h0, {31'h0, status_o.suspend});
        $display("suspend test done");
    endtask
    task automatic t_locks;
        logic [2:0] e;
        e = 3'h0;
        for (int s = 0; s < 4; s++) begin
            otp_prog_sel_i <= s[1:0];
            otp_prog_last_i <= 1'b1;
            @(posedge sys_clk_i);
            otp_prog_last_i <= 1'b0;
            if (s > 0) e[s-1] = 1'b1;
            axi(1'b0, `FSR_OFF_STATUS2, 32'h0);
            chk("lock flags", {26'h0, e, 3'h0}, rd);
            chk("program block", {28'h0, e, 1'b1}, {28'h0, otp_prog_block_o});
        end
        axi(1'b1, `FSR_OFF_STATUS2, 32'h0);
        axi(1'b0, `FSR_OFF_STATUS2, 32'h0);
        chk("locks kept", 32'h38, rd);
        $display("lock test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial forever #5 sys_clk_i = ~sys_clk_i;
    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        t_regs;
        t_suspend_flag;
        t_locks;
        report_and_stop;
    end
    initial begin
        #200000;
        n_errors++;
        report_and_stop;
    end
endmodule
bind fsr_status_two fsr_status_two_monitor i_mon (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .op_busy_i(op_busy_i),
    .hw_reset_pin_n_i(hw_reset_pin_n_i), .jedec_reset_i(jedec_reset_i),
    .otp_prog_last_i(otp_prog_last_i), .otp_prog_sel_i(otp_prog_sel_i), .status_o(status_o),
    .otp_prog_block_o(otp_prog_block_o));
`default_nettype wire
